// [logic/pfps_pkg.sv]
// pfps_pkg: register map, reset values, field positions and carrier types
// for the port function pin select block.
// assumes a 32-bit classic Wishbone bus with byte-wide registers in lane 0.
package pfps_pkg;

  localparam int ADR_W = 8;

  // register byte addresses, one aligned word each
  localparam logic [7:0] OFS_CS_EN = 8'h00;
  localparam logic [7:0] OFS_CS_ROUTE = 8'h04;
  localparam logic [7:0] OFS_BUS_CTRL = 8'h08;
  localparam logic [7:0] OFS_ADDR_HI = 8'h0C;
  localparam logic [7:0] OFS_STROBE_TCLK = 8'h10;
  localparam logic [7:0] OFS_DMA_ROUTE = 8'h14;
  localparam logic [7:0] OFS_XDMA_ROUTE = 8'h18;

  // values after reset (strap-dependent bits are loaded after release)
  localparam logic [7:0] RST_CS_EN = 8'h00;
  localparam logic [7:0] RST_CS_ROUTE = 8'h00;
  localparam logic [7:0] RST_BUS_CTRL = 8'h02;
  localparam logic [7:0] RST_ADDR_HI = 8'h00;
  localparam logic [7:0] RST_STROBE_TCLK = 8'hE0;
  localparam logic [7:0] RST_DMA_ROUTE = 8'h00;
  localparam logic [7:0] RST_XDMA_ROUTE = 8'h00;

  // writable bits and bits that always read as one
  localparam logic [7:0] WMASK_BUS_CTRL = 8'h76;
  localparam logic [7:0] WMASK_ADDR_HI = 8'h1F;
  localparam logic [7:0] WMASK_STROBE_TCLK = 8'h48;
  localparam logic [7:0] ONES_STROBE_TCLK = 8'hA0;

  // field positions
  localparam int CS0_EN_BIT = 0;
  localparam int CS2_ROUTE_BIT = 6;
  localparam int BS_ROUTE_BIT = 5;
  localparam int BS_OUT_EN_BIT = 4;
  localparam int RW_OUT_EN_BIT = 2;
  localparam int AS_OUT_EN_BIT = 1;
  localparam int UBW_EN_BIT = 6;
  localparam int TCLK_ROUTE_BIT = 3;
  localparam int ADDR_HI_LINES = 5;

  // two-bit pin-select codes
  localparam logic [1:0] ROUTE_A = 2'b00;
  localparam logic [1:0] ROUTE_B = 2'b01;

  typedef struct packed {
    logic [7:0] cs_en;
    logic [7:0] cs_route;
    logic [7:0] bus_ctrl;
    logic [7:0] addr_hi;
    logic [7:0] strobe_tclk;
    logic [7:0] dma_route;
    logic [7:0] xdma_route;
  } pfps_cfg_t;

  typedef struct packed {
    logic [3:0] pb_o;
    logic [3:0] pb_fn;
    logic [7:0] pa_o;
    logic [7:0] pa_fn;
    logic [4:0] pf_o;
    logic [4:0] pf_fn;
    logic [7:0] p1_o;
    logic [7:0] p1_fn;
    logic [5:0] p6_o;
    logic [5:0] p6_fn;
    logic [3:0] dma_req_n;
    logic [1:0] xdma_req_n;
    logic [3:0] tclk;
  } pfps_pins_t;

endpackage

// [logic/pfps_top.sv]
// pfps_top: port function pin select logic with its Wishbone register file.
// assumes peripheral strobes are active low, pin inputs are synchronous to
// CLK_I, and mode straps are stable from reset release onward.
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns

module pfps_top (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic [pfps_pkg::ADR_W-1:0] ADR_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic EXT_MODE_I,
  input wire logic ROM_DIS_I,
  input wire logic EXPAND_EN_I,
  input wire logic SDRAM_BYTE_CTRL_I,
  input wire logic [7:0] CS_N_I,
  input wire logic BS_N_I,
  input wire logic AS_N_I,
  input wire logic RW_I,
  input wire logic UB_WSTROBE_N_I,
  input wire logic [4:0] ADDR_HI_I,
  input wire logic [3:0] DMA_ACK_N_I,
  input wire logic [3:0] DMA_END_N_I,
  input wire logic [1:0] XDMA_ACK_N_I,
  input wire logic [1:0] XDMA_END_N_I,
  input wire logic [1:0] XDMA_RAK_N_I,
  input wire logic [7:0] P1_I,
  input wire logic [5:0] P6_I,
  output logic [3:0] PB_O,
  output logic [3:0] PB_FN_O,
  output logic [7:0] PA_O,
  output logic [7:0] PA_FN_O,
  output logic [4:0] PF_O,
  output logic [4:0] PF_FN_O,
  output logic [7:0] P1_O,
  output logic [7:0] P1_FN_O,
  output logic [5:0] P6_O,
  output logic [5:0] P6_FN_O,
  output logic [3:0] DMA_REQ_N_O,
  output logic [1:0] XDMA_REQ_N_O,
  output logic [3:0] TCLK_O,
  output logic TCLK_EN_O
);
  import pfps_pkg::*;

  typedef struct packed {
    pfps_cfg_t cfg;
    pfps_pins_t pins;
    logic init_done;
    logic ack;
    logic [31:0] rdata;
  } pfps_state_t;

  pfps_state_t st_r;
  pfps_state_t st_nxt;

  logic req;
  logic wr_go;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;
  logic [7:0] cs_pin_n [4];
  logic [7:0] cs_on;
  logic [1:0] cs7_code;
  logic [1:0] cs6_code;
  logic [1:0] cs5_code;
  logic [1:0] cs4_code;
  logic [1:0] dma_code [4];
  logic [1:0] xdma_code [2];
  logic [1:0] x_on_p1;
  logic [1:0] x_on_p6;
  logic [3:0] d_on;
  logic bs_on;
  logic rw_on;

  assign req = CYC_I & STB_I;
  // write lands on the edge where the master samples ack high
  assign wr_go = req & st_r.ack & WE_I & SEL_I[0];
  assign wbyte = DAT_I[7:0];

  assign cs7_code = st_r.cfg.cs_route[7:6];
  assign cs6_code = st_r.cfg.cs_route[5:4];
  assign cs5_code = st_r.cfg.cs_route[3:2];
  assign cs4_code = st_r.cfg.cs_route[1:0];

  // register readback; reserved bits are forced here and again when written, except the ext DMA register's upper four
  always_comb begin
    unique case (ADR_I)
      OFS_CS_EN: rd_byte = st_r.cfg.cs_en;
      OFS_CS_ROUTE: rd_byte = st_r.cfg.cs_route;
      OFS_BUS_CTRL: rd_byte = st_r.cfg.bus_ctrl & WMASK_BUS_CTRL;
      OFS_ADDR_HI: rd_byte = st_r.cfg.addr_hi & WMASK_ADDR_HI;
      OFS_STROBE_TCLK: rd_byte = (st_r.cfg.strobe_tclk & WMASK_STROBE_TCLK)
                                 | ONES_STROBE_TCLK;
      OFS_DMA_ROUTE: rd_byte = st_r.cfg.dma_route;
      OFS_XDMA_ROUTE: rd_byte = st_r.cfg.xdma_route;
      default: rd_byte = 8'h00;
    endcase
  end

  // chip-select routing: each pin collects every select mapped onto it
  always_comb begin
    cs_on = st_r.cfg.cs_en & {8{EXPAND_EN_I}};
    for (int p = 0; p < 4; p++) begin
      cs_pin_n[p] = 8'hFF;
    end
    if (cs_on[7] && cs7_code == ROUTE_A) begin
      cs_pin_n[3][7] = CS_N_I[7];
    end
    if (cs_on[7] && cs7_code == ROUTE_B) begin
      cs_pin_n[1][7] = CS_N_I[7];
    end
    if (cs_on[6] && cs6_code == ROUTE_A) begin
      cs_pin_n[2][6] = CS_N_I[6];
    end
    if (cs_on[6] && cs6_code == ROUTE_B) begin
      cs_pin_n[1][6] = CS_N_I[6];
    end
    if (cs_on[5] && cs5_code == ROUTE_A) begin
      cs_pin_n[1][5] = CS_N_I[5];
    end
    if (cs_on[5] && cs5_code == ROUTE_B) begin
      cs_pin_n[0][5] = CS_N_I[5];
    end
    if (cs_on[4] && cs4_code == ROUTE_A) begin
      cs_pin_n[0][4] = CS_N_I[4];
    end
    if (cs_on[3]) begin
      cs_pin_n[3][3] = CS_N_I[3];
    end
    if (cs_on[2] && !st_r.cfg.bus_ctrl[CS2_ROUTE_BIT]) begin
      cs_pin_n[2][2] = CS_N_I[2];
    end
    if (cs_on[2] && st_r.cfg.bus_ctrl[CS2_ROUTE_BIT]) begin
      cs_pin_n[1][2] = CS_N_I[2];
    end
    if (cs_on[1]) begin
      cs_pin_n[1][1] = CS_N_I[1];
    end
    if (cs_on[0]) begin
      cs_pin_n[0][0] = CS_N_I[0];
    end
  end

  // DMA pin-select decode; prohibited codes simply route nothing
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      dma_code[c] = st_r.cfg.dma_route[2*c +: 2];
    end
    for (int c = 0; c < 2; c++) begin
      xdma_code[c] = st_r.cfg.xdma_route[2*c +: 2];
      x_on_p1[c] = (xdma_code[c] == ROUTE_A);
      x_on_p6[c] = (xdma_code[c] == ROUTE_B);
    end
    d_on[0] = (dma_code[0] == ROUTE_A);
    d_on[1] = (dma_code[1] == ROUTE_A);
    d_on[2] = (dma_code[2] == ROUTE_B);
    d_on[3] = (dma_code[3] == ROUTE_B);
  end

  assign bs_on = EXPAND_EN_I & st_r.cfg.bus_ctrl[BS_OUT_EN_BIT];
  assign rw_on = EXPAND_EN_I &
                 (st_r.cfg.bus_ctrl[RW_OUT_EN_BIT] | SDRAM_BYTE_CTRL_I);

  always_comb begin
    st_nxt = st_r;

    // bus slave: one wait state, ack dropped the cycle after it is given
    st_nxt.ack = req & ~st_r.ack & st_r.init_done;
    if (req & ~st_r.ack) begin
      st_nxt.rdata = {24'h00_0000, rd_byte};
    end

    // straps are caught on the first clock after reset release
    if (!st_r.init_done) begin
      st_nxt.init_done = 1'b1;
      st_nxt.cfg.cs_en[CS0_EN_BIT] = EXT_MODE_I;
      st_nxt.cfg.addr_hi = {3'b000, {ADDR_HI_LINES{ROM_DIS_I}}};
    end

    // writes take effect at ack edge
    if (wr_go) begin
      unique case (ADR_I)
        OFS_CS_EN: st_nxt.cfg.cs_en = wbyte;
        OFS_CS_ROUTE: st_nxt.cfg.cs_route = wbyte;
        OFS_BUS_CTRL: st_nxt.cfg.bus_ctrl = wbyte & WMASK_BUS_CTRL;
        OFS_ADDR_HI: st_nxt.cfg.addr_hi = wbyte & WMASK_ADDR_HI;
        OFS_STROBE_TCLK: st_nxt.cfg.strobe_tclk =
          (wbyte & WMASK_STROBE_TCLK) | ONES_STROBE_TCLK;
        OFS_DMA_ROUTE: st_nxt.cfg.dma_route = wbyte;
        OFS_XDMA_ROUTE: st_nxt.cfg.xdma_route = wbyte;
        default: st_nxt.cfg = st_r.cfg;
      endcase
    end

    // pin outputs are registered so every data output comes from a flop
    for (int p = 0; p < 4; p++) begin
      st_nxt.pins.pb_o[p] = &cs_pin_n[p];
    end
    st_nxt.pins.pb_fn[3] = cs_on[3] | (cs_on[7] & (cs7_code == ROUTE_A));
    st_nxt.pins.pb_fn[2] = (cs_on[2] & ~st_r.cfg.bus_ctrl[CS2_ROUTE_BIT])
                           | (cs_on[6] & (cs6_code == ROUTE_A));
    st_nxt.pins.pb_fn[1] = cs_on[1]
                           | (cs_on[2] & st_r.cfg.bus_ctrl[CS2_ROUTE_BIT])
                           | (cs_on[5] & (cs5_code == ROUTE_A))
                           | (cs_on[6] & (cs6_code == ROUTE_B))
                           | (cs_on[7] & (cs7_code == ROUTE_B));
    st_nxt.pins.pb_fn[0] = cs_on[0]
                           | (cs_on[4] & (cs4_code == ROUTE_A))
                           | (cs_on[5] & (cs5_code == ROUTE_B));

    st_nxt.pins.pa_o = 8'hFF;
    st_nxt.pins.pa_fn = 8'h00;
    if (bs_on && !st_r.cfg.bus_ctrl[BS_ROUTE_BIT]) begin
      st_nxt.pins.pa_o[0] = BS_N_I;
      st_nxt.pins.pa_fn[0] = 1'b1;
    end
    if (rw_on) begin
      st_nxt.pins.pa_o[1] = RW_I;
      st_nxt.pins.pa_fn[1] = 1'b1;
    end
    if (EXPAND_EN_I && EXT_MODE_I && st_r.cfg.strobe_tclk[UBW_EN_BIT]) begin
      st_nxt.pins.pa_o[4] = UB_WSTROBE_N_I;
      st_nxt.pins.pa_fn[4] = 1'b1;
    end
    if (EXPAND_EN_I && st_r.cfg.bus_ctrl[AS_OUT_EN_BIT]) begin
      st_nxt.pins.pa_o[6] = AS_N_I;
      st_nxt.pins.pa_fn[6] = 1'b1;
    end
    // two strobes on A6 share it like chip selects do
    if (bs_on && st_r.cfg.bus_ctrl[BS_ROUTE_BIT]) begin
      st_nxt.pins.pa_o[6] = st_nxt.pins.pa_o[6] & BS_N_I;
      st_nxt.pins.pa_fn[6] = 1'b1;
    end

    for (int a = 0; a < ADDR_HI_LINES; a++) begin
      st_nxt.pins.pf_fn[a] = EXPAND_EN_I & st_r.cfg.addr_hi[a];
      st_nxt.pins.pf_o[a] = st_nxt.pins.pf_fn[a] & ADDR_HI_I[a];
    end

    // port 1: DMA 0 on bits 0-2, DMA 1 on 4-6, ext DMA on 0-3 / 4-7
    st_nxt.pins.p1_o = 8'hFF;
    st_nxt.pins.p1_fn = 8'h00;
    st_nxt.pins.p6_o = 6'h3F;
    st_nxt.pins.p6_fn = 6'h00;
    st_nxt.pins.dma_req_n = 4'hF;
    st_nxt.pins.xdma_req_n = 2'b11;
    for (int c = 0; c < 2; c++) begin
      if (x_on_p1[c]) begin
        st_nxt.pins.xdma_req_n[c] = P1_I[4*c];
        st_nxt.pins.p1_o[4*c+1] = XDMA_ACK_N_I[c];
        st_nxt.pins.p1_o[4*c+2] = XDMA_END_N_I[c];
        st_nxt.pins.p1_o[4*c+3] = XDMA_RAK_N_I[c];
        st_nxt.pins.p1_fn[4*c+1 +: 3] = 3'b111;
      end
      if (x_on_p6[c]) begin
        st_nxt.pins.xdma_req_n[c] = P6_I[3*c];
        st_nxt.pins.p6_o[3*c+1] = XDMA_END_N_I[c];
        st_nxt.pins.p6_o[3*c+2] = XDMA_ACK_N_I[c];
        st_nxt.pins.p6_fn[3*c+1 +: 2] = 2'b11;
      end
      if (d_on[c]) begin
        st_nxt.pins.dma_req_n[c] = P1_I[4*c];
        st_nxt.pins.p1_o[4*c+1] = st_nxt.pins.p1_o[4*c+1] & DMA_ACK_N_I[c];
        st_nxt.pins.p1_o[4*c+2] = st_nxt.pins.p1_o[4*c+2] & DMA_END_N_I[c];
        st_nxt.pins.p1_fn[4*c+1 +: 2] = 2'b11;
      end
      if (d_on[c+2]) begin
        st_nxt.pins.dma_req_n[c+2] = P6_I[3*c];
        st_nxt.pins.p6_o[3*c+1] = st_nxt.pins.p6_o[3*c+1] & DMA_END_N_I[c+2];
        st_nxt.pins.p6_o[3*c+2] = st_nxt.pins.p6_o[3*c+2] & DMA_ACK_N_I[c+2];
        st_nxt.pins.p6_fn[3*c+1 +: 2] = 2'b11;
      end
    end

    st_nxt.pins.tclk = st_r.cfg.strobe_tclk[TCLK_ROUTE_BIT] ? P1_I[7:4]
                                                             : 4'h0;
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_r.cfg <= '{cs_en: RST_CS_EN, cs_route: RST_CS_ROUTE,
                    bus_ctrl: RST_BUS_CTRL, addr_hi: RST_ADDR_HI,
                    strobe_tclk: RST_STROBE_TCLK,
                    dma_route: RST_DMA_ROUTE,
                    xdma_route: RST_XDMA_ROUTE};
      st_r.pins <= '{pb_o: 4'hF, pb_fn: 4'h0, pa_o: 8'hFF, pa_fn: 8'h00,
                     pf_o: 5'h00, pf_fn: 5'h00, p1_o: 8'hFF, p1_fn: 8'h00,
                     p6_o: 6'h3F, p6_fn: 6'h00, dma_req_n: 4'hF,
                     xdma_req_n: 2'b11, tclk: 4'h0};
      st_r.init_done <= 1'b0;
      st_r.ack <= 1'b0;
      st_r.rdata <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign DAT_O = st_r.rdata;
  assign ACK_O = st_r.ack;
  assign PB_O = st_r.pins.pb_o;
  assign PB_FN_O = st_r.pins.pb_fn;
  assign PA_O = st_r.pins.pa_o;
  assign PA_FN_O = st_r.pins.pa_fn;
  assign PF_O = st_r.pins.pf_o;
  assign PF_FN_O = st_r.pins.pf_fn;
  assign P1_O = st_r.pins.p1_o;
  assign P1_FN_O = st_r.pins.p1_fn;
  assign P6_O = st_r.pins.p6_o;
  assign P6_FN_O = st_r.pins.p6_fn;
  assign DMA_REQ_N_O = st_r.pins.dma_req_n;
  assign XDMA_REQ_N_O = st_r.pins.xdma_req_n;
  assign TCLK_O = st_r.pins.tclk;
  assign TCLK_EN_O = st_r.cfg.strobe_tclk[TCLK_ROUTE_BIT];

endmodule // pfps_top

// [dv/pfps_top_properties.sv]
// pfps_top_properties: port-level checks of the pin select block.
// assumes one CLK_I domain, RST_N_I async active-low, bound below.
`timescale 1ns/1ns
module pfps_top_properties (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic ACK_O,
  input wire logic [31:0] DAT_O,
  input wire logic EXPAND_EN_I,
  input wire logic SDRAM_BYTE_CTRL_I,
  input wire logic RW_I,
  input wire logic [7:0] CS_N_I,
  input wire logic [4:0] ADDR_HI_I,
  input wire logic [7:0] P1_I,
  input wire logic [3:0] PB_O,
  input wire logic [3:0] PB_FN_O,
  input wire logic [7:0] PA_O,
  input wire logic [7:0] PA_FN_O,
  input wire logic [4:0] PF_O,
  input wire logic [4:0] PF_FN_O,
  input wire logic [3:0] TCLK_O,
  input wire logic TCLK_EN_O
);
  logic [1:0] live_r;
  logic live;
  // pins only follow config once straps are latched, so wait a few edges
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) live_r <= 2'h0;
    else if (live_r != 2'h3) live_r <= live_r + 2'h1;
  end
  assign live = (live_r == 2'h3);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  chk_ack_pulse: assert property (ACK_O |=> !ACK_O)
    else $error("ack held over one cycle");
  chk_ack_cause: assert property (ACK_O |-> $past(CYC_I && STB_I))
    else $error("ack without request");
  chk_data_upper: assert property (ACK_O |-> DAT_O[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  chk_rw_forced: assert property (live && $past(SDRAM_BYTE_CTRL_I)
    && $past(EXPAND_EN_I) |-> PA_FN_O[1] && PA_O[1] == $past(RW_I))
    else $error("read/write pin not forced");
  chk_tclk_route: assert property (live && TCLK_EN_O && $past(TCLK_EN_O)
    |-> TCLK_O == $past(P1_I[7:4]))
    else $error("timer clock not from port 1");
  chk_tclk_off: assert property (live && !TCLK_EN_O && !$past(TCLK_EN_O)
    |-> TCLK_O == 4'h0)
    else $error("timer clock passes while off");
  chk_addr_drive: assert property (live
    |-> PF_O == ($past(ADDR_HI_I) & PF_FN_O))
    else $error("address line value wrong");
  chk_no_expand: assert property (live && !$past(EXPAND_EN_I)
    |-> PB_FN_O == 4'h0 && PF_FN_O == 5'h00 && PA_FN_O == 8'h00)
    else $error("bus pin owned without expansion");
  chk_pb_idle: assert property (live |-> (PB_O | PB_FN_O) == 4'hF)
    else $error("unowned select pin low");
  chk_cs_idle: assert property (live && $past(&CS_N_I) |-> PB_O == 4'hF)
    else $error("select pin low with no select");
endmodule // pfps_top_properties

bind pfps_top pfps_top_properties u_props (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O), .DAT_O(DAT_O),
  .EXPAND_EN_I(EXPAND_EN_I), .SDRAM_BYTE_CTRL_I(SDRAM_BYTE_CTRL_I),
  .RW_I(RW_I), .CS_N_I(CS_N_I), .ADDR_HI_I(ADDR_HI_I), .P1_I(P1_I),
  .PB_O(PB_O), .PB_FN_O(PB_FN_O), .PA_O(PA_O), .PA_FN_O(PA_FN_O),
  .PF_O(PF_O), .PF_FN_O(PF_FN_O), .TCLK_O(TCLK_O), .TCLK_EN_O(TCLK_EN_O));

// [dv/pfps_pin_partner.sv]
// pfps_pin_partner: far-side devices driving port 1 and port 6 pins.
// assumes the bench clock; levels move every cycle so stale samples show.
`timescale 1ns/1ns
module pfps_pin_partner (
  input wire logic clk_i,
  input wire logic rst_n_i,
  output logic [7:0] p1_o,
  output logic [5:0] p6_o
);
  logic [13:0] lfsr_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) lfsr_r <= 14'h12A5;
    else lfsr_r <= {lfsr_r[12:0], lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[1]};
  end
  assign p1_o = lfsr_r[7:0];
  assign p6_o = lfsr_r[13:8];
endmodule // pfps_pin_partner

// [dv/pfps_top_bench.sv]
// pfps_top_bench: self-checking bench with a register and pin model.
// assumes the partner drives ports 1/6 and the checker is bound.
`timescale 1ns/1ns
module pfps_top_bench;
  import pfps_pkg::*;
  logic clk, rst_n, cyc, stb, we, ext, rom, expd, sdr, rw, bsn, asn, ubn;
  logic tcke, ack;
  logic [3:0] sel, pb, pbf, dma_request_in, tck;
  logic [7:0] adr, chip_select_line, pa, paf, p1, p1q, q, p1o, p1f;
  logic [5:0] p6, p6q, p6o, p6f;
  logic [4:0] ahi, pf, pff;
  logic [1:0] xreq;
  logic [13:0] dmx;
  logic [31:0] dw, dr;
  logic [7:0] mreg [7];
  logic [7:0] lm [7] = '{8'hFF, 8'hFF, 8'h76, 8'h1F, 8'h48, 8'hFF, 8'h0F};
  int num_errors = 0;
  int num_checks = 0;
  pfps_top dut (.CLK_I(clk), .RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .SEL_I(sel), .ADR_I(adr), .DAT_I(dw), .DAT_O(dr),
    .ACK_O(ack), .EXT_MODE_I(ext), .ROM_DIS_I(rom), .EXPAND_EN_I(expd),
    .SDRAM_BYTE_CTRL_I(sdr), .CS_N_I(chip_select_line), .BS_N_I(bsn), .AS_N_I(asn),
    .RW_I(rw), .UB_WSTROBE_N_I(ubn), .ADDR_HI_I(ahi),
    .DMA_ACK_N_I(dmx[3:0]), .DMA_END_N_I(dmx[7:4]),
    .XDMA_ACK_N_I(dmx[9:8]), .XDMA_END_N_I(dmx[11:10]),
    .XDMA_RAK_N_I(dmx[13:12]), .P1_I(p1), .P6_I(p6), .PB_O(pb),
    .PB_FN_O(pbf), .PA_O(pa), .PA_FN_O(paf), .PF_O(pf), .PF_FN_O(pff),
    .P1_O(p1o), .P1_FN_O(p1f), .P6_O(p6o), .P6_FN_O(p6f), .DMA_REQ_N_O(dma_request_in),
    .XDMA_REQ_N_O(xreq), .TCLK_O(tck), .TCLK_EN_O(tcke));
  pfps_pin_partner u_pins (.clk_i(clk), .rst_n_i(rst_n), .p1_o(p1),
    .p6_o(p6));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic wrap_up();
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e,
                     input string what);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  function automatic logic [7:0] rexp(input int i);
    return (mreg[i] & lm[i]) | (i == 4 ? 8'hA0 : 8'h00);
  endfunction
  // one classic cycle; waits for ack, then idles a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= {24'h00_0000, d};
    sel <= 4'h1;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    cmp(ack, 1'b1, "no ack");
    q = dr[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    if (w && a[1:0] == 2'h0 && a < 8'h1C) mreg[a[4:2]] = d;
  endtask
  task automatic pins();
    int pin [8];
    logic [7:0] c, r, b, s, d, x, af, ao;
    logic [4:0] h;
    logic [3:0] f, o;
    logic [7:0] o1, f1;
    logic [5:0] o6, f6;
    @(posedge clk);
    p1q = p1;
    p6q = p6;
    @(posedge clk);
    c = rexp(0) & {8{expd}};
    r = rexp(1);
    b = rexp(2);
    h = 5'(rexp(3)) & {5{expd}};
    s = rexp(4);
    d = rexp(5);
    x = rexp(6);
    // prohibited codes route nothing
    pin = '{0, 1, b[6] ? 1 : 2, 3, r[1:0] == 2'h0 ? 0 : -1,
      r[3:2] == 2'h0 ? 1 : (r[3:2] == 2'h1 ? 0 : -1),
      r[5:4] == 2'h0 ? 2 : (r[5:4] == 2'h1 ? 1 : -1),
      r[7:6] == 2'h0 ? 3 : (r[7:6] == 2'h1 ? 1 : -1)};
    f = 4'h0;
    o = 4'hF;
    for (int i = 0; i < 8; i++) begin
      if (c[i] && pin[i] >= 0) begin
        f[pin[i]] = 1'b1;
        o[pin[i]] = o[pin[i]] & chip_select_line[i];
      end
    end
    cmp({pbf, pb}, {f, o}, "select pins");
    af = {1'b0, expd & (b[1] | (b[4] & b[5])), 1'b0, expd & s[6] & ext,
      2'h0, expd & (b[2] | sdr), expd & b[4] & ~b[5]};
    ao = {1'b1, (~(expd & b[1]) | asn) & (~(expd & b[4] & b[5]) | bsn),
      1'b1, ~af[4] | ubn, 2'h3, ~af[1] | rw, ~af[0] | bsn};
    cmp({paf, pa}, {af, ao}, "port A pins");
    cmp({pff, pf}, {h, ahi & h}, "address pins");
    cmp({tcke, tck}, {s[3], s[3] ? p1q[7:4] : 4'h0}, "timer clk");
    cmp(dma_request_in, {d[7:6] == 2'h1 ? p6q[3] : 1'b1,
      d[5:4] == 2'h1 ? p6q[0] : 1'b1, d[3:2] == 2'h0 ? p1q[4] : 1'b1,
      d[1:0] == 2'h0 ? p1q[0] : 1'b1}, "dma requests");
    cmp(xreq, {x[3:2] == 2'h0 ? p1q[4] : (x[3:2] == 2'h1 ? p6q[3] : 1'b1),
      x[1:0] == 2'h0 ? p1q[0] : (x[1:0] == 2'h1 ? p6q[0] : 1'b1)},
      "ext dma requests");
    // shared ack/end pins of on-chip and ext DMA are ANDed, idle high
    o1 = 8'hFF;
    f1 = 8'h00;
    o6 = 6'h3F;
    f6 = 6'h00;
    for (int k = 0; k < 2; k++) begin
      if (x[2*k +: 2] == 2'h0) begin
        f1[4*k+1 +: 3] = 3'h7;
        o1[4*k+1 +: 3] = {dmx[12+k], dmx[10+k], dmx[8+k]};
      end
      if (x[2*k +: 2] == 2'h1) begin
        f6[3*k+1 +: 2] = 2'h3;
        o6[3*k+1 +: 2] = {dmx[8+k], dmx[10+k]};
      end
      if (d[2*k +: 2] == 2'h0) begin
        f1[4*k+1 +: 2] = 2'h3;
        o1[4*k+1 +: 2] = o1[4*k+1 +: 2] & {dmx[4+k], dmx[k]};
      end
      if (d[2*k+4 +: 2] == 2'h1) begin
        f6[3*k+1 +: 2] = 2'h3;
        o6[3*k+1 +: 2] = o6[3*k+1 +: 2] & {dmx[2+k], dmx[6+k]};
      end
    end
    cmp({p1f, p1o, p6f, p6o}, {f1, o1, f6, o6}, "dma pins");
  endtask
  task automatic do_reset(input logic e, input logic rm);
    ext <= e;
    rom <= rm;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    mreg = '{{7'h00, e}, 8'h00, 8'h02, rm ? 8'h1F : 8'h00, 8'hE0, 8'h00,
      8'h00};
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, 8'(i * 4), 8'h00);
      cmp(q, i < 7 ? rexp(i) : 8'h00, "reset value");
    end
    pins();
  endtask
  initial begin
    {cyc, stb, we, sel, adr, dw, expd, sdr, rw, bsn, asn, ubn} = '0;
    {chip_select_line, ahi, dmx} = '1;
    {ext, rom, rst_n} = 3'h0;
    void'($urandom(22202));
    @(posedge clk);
    // reset routing on the select, port A and address pins is only visible with the external bus enabled
    expd <= 1'b1;
    do_reset(1'b1, 1'b1);
    for (int i = 0; i < 8; i++) begin
      // ext DMA reserved bits written as zero
      wb(1'b1, 8'(i * 4), i == 6 ? 8'h0F : 8'hFF);
      wb(1'b0, 8'(i * 4), 8'h00);
      cmp(q, i < 7 ? rexp(i) : 8'h00, "reserved bits");
    end
    repeat (60) begin
      {expd, sdr, rw, bsn, asn, ubn, chip_select_line, ahi} <= 19'($urandom);
      dmx <= 14'($urandom);
      for (int i = 0; i < 7; i++) begin
        wb(1'b1, 8'(i * 4), (8'($urandom) & lm[i]) | (i == 4 ? 8'hA0 : 8'h00));
      end
      pins();
    end
    do_reset(1'b0, 1'b0);
    wrap_up();
  end
  initial begin
    #100000;
    num_errors++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    wrap_up();
  end
endmodule // pfps_top_bench
